// file: hw/nvac_cfg.svh
`ifndef NVAC_CFG_SVH
`define NVAC_CFG_SVH
// register indices (byte address divided by four)
`define NVAC_IDX_FLAGS 8'h0C
`define NVAC_IDX_ENABLES 8'h8C
`define NVAC_IDX_DATA 8'h9A
`define NVAC_IDX_ADDR 8'h9B
`define NVAC_IDX_CTRL 8'h9C
`define NVAC_IDX_UNLOCK 8'h9D
`define NVAC_IDX_IRQ_STATUS 8'hA0
`define NVAC_IDX_IRQ_CLEAR 8'hA1
`define NVAC_IDX_IRQ_ENABLE 8'hA2
`define NVAC_ADDR_W 10
// field positions
`define NVAC_CTRL_RD 0
`define NVAC_CTRL_WR 1
`define NVAC_CTRL_WRITE_ENABLE_GATE 2
`define NVAC_CTRL_WRITE_ERROR_FLAG 3
`define NVAC_FLAG_DONE 7
`define NVAC_IRQ_WR_DONE 0
`define NVAC_IRQ_WR_ERR 1
`define NVAC_IRQ_RD_DONE 2
// unlock key bytes
`define NVAC_KEY1 8'h55
`define NVAC_KEY2 8'hAA
// write time in ns, cycle count derived at 5 ns clock
`define NVAC_WRITE_NS 4000000
`define NVAC_CLK_NS 5
`define NVAC_WRITE_CYC (`NVAC_WRITE_NS / `NVAC_CLK_NS)
`define NVAC_RESET_BYTE 8'h00
`endif

// file: hw/nvac_pkg.sv
`default_nettype none
package nvac_pkg;
    typedef enum logic [2:0] {
        NVAC_IDLE = 3'b001,
        NVAC_KEY_A = 3'b010,
        NVAC_KEY_B = 3'b100
    } nvac_unlock_t;

    typedef enum logic [1:0] {
        NVAC_READY = 2'b01,
        NVAC_WRITING = 2'b10
    } nvac_wstate_t;

    typedef struct packed {
        logic wr_err;
        logic write_enable_gate;
        logic wr;
        logic rd;
    } nvac_ctrl_t;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] data;
        logic we;
    } nvac_mem_req_t;
endpackage
`default_nettype wire

// file: hw/nvac_top.sv
// Contract
// - only address bits 6:0 select a byte; bit 7 is ignored.
// - control bits 7:4 are absent and read as zero.
// - read and write triggers set by software, cleared only by hardware.
// - read trigger loads the addressed byte in one cycle, then clears.
// - writes run only with write enable set; enable clears at power-up.
// - write error flag sets when an external or watchdog reset interrupts a running write.
// - reset aborting a write leaves data and address registers cleared.
// - write done flag set by hardware, cleared only by software.
// - unlock register holds nothing, reads zero, feeds the unlock sequence.
// - write completing during sleep sets flag bit 7 too.
//
// The implementer's own choice: the Avalon-MM register port.
`include "nvac_cfg.svh"
`default_nettype none

module nvac_top #(
    parameter int WRITE_CYCLES = `NVAC_WRITE_CYC
) (
    // clock, resets and sleep
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic POWER_ON_RESET_I,
    input wire logic WATCHDOG_RESET_I,
    input wire logic SLEEP_I,
    // avalon-mm slave
    input wire logic [`NVAC_ADDR_W-1:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    output logic [1:0] AVS_RESPONSE_O,
    // interrupts
    output logic NVM_IRQ_O,
    output logic EVENT_IRQ_O
);

    //------------------------------------------------------------
    // reset sources and sleep synchronisers
    //------------------------------------------------------------
    logic [1:0] por_sync_reg;
    logic [1:0] wdt_sync_reg;
    logic [1:0] slp_sync_reg;
    always_ff @(posedge CLK_I) begin
        por_sync_reg <= {por_sync_reg[0], POWER_ON_RESET_I};
        wdt_sync_reg <= {wdt_sync_reg[0], WATCHDOG_RESET_I};
        slp_sync_reg <= {slp_sync_reg[0], SLEEP_I};
    end
    wire por = por_sync_reg[1];
    wire wdt_rst = wdt_sync_reg[1];
    wire asleep = slp_sync_reg[1];
    // external reset pin arrives on RESET_I, watchdog resets only when awake
    wire abort_rst = RESET_I | (wdt_rst & ~asleep);
    wire any_rst = abort_rst | por;

    //------------------------------------------------------------
    // registers and memory
    //------------------------------------------------------------
    logic [7:0] mem [0:127];
    logic [7:0] data_reg;
    logic [7:0] addr_reg;
    nvac_pkg::nvac_ctrl_t ctrl_reg;
    logic done_flag_reg;
    logic done_ie_reg;
    logic [2:0] irq_status_reg;
    logic [2:0] irq_enable_reg;
    nvac_pkg::nvac_unlock_t unlock_reg;
    nvac_pkg::nvac_wstate_t wstate_reg;
    logic [31:0] wcount_reg;
    logic [7:0] wr_data_reg;
    logic [6:0] wr_addr_reg;
    logic ack_reg;

    //------------------------------------------------------------
    // bus decode
    //------------------------------------------------------------
    wire req = (AVS_READ_I | AVS_WRITE_I) & ~ack_reg;
    wire [7:0] idx = AVS_ADDRESS_I[`NVAC_ADDR_W-1:2];
    wire wr_ok = req & AVS_WRITE_I & AVS_BYTEENABLE_I[0];
    wire [7:0] wb = AVS_WRITEDATA_I[7:0];
    wire hit_flags = idx == `NVAC_IDX_FLAGS;
    wire hit_en = idx == `NVAC_IDX_ENABLES;
    wire hit_data = idx == `NVAC_IDX_DATA;
    wire hit_addr = idx == `NVAC_IDX_ADDR;
    wire hit_ctrl = idx == `NVAC_IDX_CTRL;
    wire hit_unl = idx == `NVAC_IDX_UNLOCK;
    wire hit_ist = idx == `NVAC_IDX_IRQ_STATUS;
    wire hit_icl = idx == `NVAC_IDX_IRQ_CLEAR;
    wire hit_ien = idx == `NVAC_IDX_IRQ_ENABLE;
    wire mapped = hit_flags | hit_en | hit_data | hit_addr | hit_ctrl | hit_unl
                  | hit_ist | hit_icl | hit_ien;
    wire w_ctrl = wr_ok & hit_ctrl;
    wire w_unl = wr_ok & hit_unl;
    wire [7:0] ctrl_rd = {4'h0, ctrl_reg};
    wire [7:0] flags_rd = {done_flag_reg, 7'h00};
    wire [7:0] en_rd = {done_ie_reg, 7'h00};
    wire [7:0] rd_byte = hit_ctrl ? ctrl_rd :
                         hit_data ? data_reg :
                         hit_addr ? addr_reg :
                         hit_flags ? flags_rd :
                         hit_en ? en_rd :
                         hit_ist ? {5'h00, irq_status_reg} :
                         hit_ien ? {5'h00, irq_enable_reg} :
                         8'h00; // unlock reads zero

    //------------------------------------------------------------
    // unlock sequence and triggers
    //------------------------------------------------------------
    wire unlocked = unlock_reg == nvac_pkg::NVAC_KEY_B;
    wire set_rd = w_ctrl & wb[`NVAC_CTRL_RD];
    wire set_wr = w_ctrl & wb[`NVAC_CTRL_WR] & ~ctrl_reg.wr;
    wire write_enable_gate_now = w_ctrl ? wb[`NVAC_CTRL_WRITE_ENABLE_GATE] : ctrl_reg.write_enable_gate;
    wire start_wr = set_wr & unlocked & write_enable_gate_now;
    wire wr_busy = wstate_reg == nvac_pkg::NVAC_WRITING;
    wire wr_finish = wr_busy & (wcount_reg == 32'h0000_0001);
    wire sw_clr_done = wr_ok & hit_flags & ~wb[`NVAC_FLAG_DONE];
    wire [2:0] ev = {set_rd, abort_rst & wr_busy, wr_finish};
    wire [2:0] icl = (wr_ok & hit_icl) ? wb[2:0] : 3'h0;

    nvac_pkg::nvac_unlock_t unlock_next;
    always_comb begin
        unlock_next = nvac_pkg::NVAC_IDLE;
        if (w_unl) begin
            unique case (unlock_reg)
                nvac_pkg::NVAC_IDLE: begin
                    unlock_next = (wb == `NVAC_KEY1) ? nvac_pkg::NVAC_KEY_A : nvac_pkg::NVAC_IDLE;
                end
                nvac_pkg::NVAC_KEY_A: begin
                    unlock_next = (wb == `NVAC_KEY2) ? nvac_pkg::NVAC_KEY_B : nvac_pkg::NVAC_IDLE;
                end
                nvac_pkg::NVAC_KEY_B: begin
                    unlock_next = nvac_pkg::NVAC_IDLE;
                end
                default: begin
                    unlock_next = nvac_pkg::NVAC_IDLE;
                end
            endcase
        end else if (!w_ctrl) begin
            unlock_next = unlock_reg;
        end
    end

    //------------------------------------------------------------
    // bus answer: one wait cycle, then ack
    //------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            ack_reg <= 1'b0;
            AVS_WAITREQUEST_O <= 1'b1;
            AVS_READDATA_O <= 32'h0000_0000;
            AVS_RESPONSE_O <= 2'b00;
        end else begin
            ack_reg <= req;
            AVS_WAITREQUEST_O <= ~req;
            AVS_READDATA_O <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            AVS_RESPONSE_O <= (req && !mapped) ? 2'b11 : 2'b00;
        end
    end

    //------------------------------------------------------------
    // data, address, control
    //------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (any_rst) begin
            data_reg <= `NVAC_RESET_BYTE;
            addr_reg <= `NVAC_RESET_BYTE;
            ctrl_reg.rd <= 1'b0;
            ctrl_reg.wr <= 1'b0;
            ctrl_reg.write_enable_gate <= 1'b0;
            if (por) begin
                ctrl_reg.wr_err <= 1'b0;
            end else if (wr_busy) begin
                ctrl_reg.wr_err <= 1'b1;
            end
            unlock_reg <= nvac_pkg::NVAC_IDLE;
        end else begin
            unlock_reg <= unlock_next;
            if (set_rd) begin
                data_reg <= mem[addr_reg[6:0]];
            end else if (wr_ok && hit_data) begin
                data_reg <= wb;
            end
            if (wr_ok && hit_addr) begin
                addr_reg <= wb;
            end
            ctrl_reg.rd <= 1'b0;
            if (start_wr) begin
                ctrl_reg.wr <= 1'b1;
            end else if (wr_finish) begin
                ctrl_reg.wr <= 1'b0;
            end
            if (w_ctrl) begin
                ctrl_reg.write_enable_gate <= wb[`NVAC_CTRL_WRITE_ENABLE_GATE];
                ctrl_reg.wr_err <= wb[`NVAC_CTRL_WRITE_ERROR_FLAG];
            end
        end
    end

    //------------------------------------------------------------
    // write engine
    //------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (any_rst) begin
            wstate_reg <= nvac_pkg::NVAC_READY;
            wcount_reg <= 32'h0000_0000;
            wr_data_reg <= `NVAC_RESET_BYTE;
            wr_addr_reg <= 7'h00;
        end else if (start_wr) begin
            wstate_reg <= nvac_pkg::NVAC_WRITING;
            wcount_reg <= 32'(WRITE_CYCLES);
            wr_data_reg <= data_reg;
            wr_addr_reg <= addr_reg[6:0];
        end else if (wr_finish) begin
            wstate_reg <= nvac_pkg::NVAC_READY;
            wcount_reg <= 32'h0000_0000;
        end else if (wr_busy) begin
            wcount_reg <= wcount_reg - 32'h0000_0001;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (wr_finish && !any_rst) begin
            mem[wr_addr_reg] <= wr_data_reg;
        end
    end

    //------------------------------------------------------------
    // peripheral flags, event status, interrupts
    //------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (RESET_I || por) begin
            done_flag_reg <= 1'b0;
            done_ie_reg <= 1'b0;
            irq_status_reg <= 3'h0;
            irq_enable_reg <= 3'h0;
            NVM_IRQ_O <= 1'b0;
            EVENT_IRQ_O <= 1'b0;
        end else begin
            if (wr_finish) begin
                done_flag_reg <= 1'b1;
            end else if (sw_clr_done) begin
                done_flag_reg <= 1'b0;
            end
            if (wr_ok && hit_en) begin
                done_ie_reg <= wb[`NVAC_FLAG_DONE];
            end
            if (wr_ok && hit_ien) begin
                irq_enable_reg <= wb[2:0];
            end
            irq_status_reg <= ev | (irq_status_reg & ~icl);
            NVM_IRQ_O <= (done_flag_reg | wr_finish) & done_ie_reg;
            EVENT_IRQ_O <= |((irq_status_reg | ev) & irq_enable_reg);
        end
    end

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    a_ctrl_upper_zero: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (!AVS_WAITREQUEST_O && $past(hit_ctrl)) |-> AVS_READDATA_O[7:4] == 4'h0)
        else $error("control upper bits not zero");
    a_rd_self_clear: assert property (@(posedge CLK_I) disable iff (any_rst)
        set_rd |=> !ctrl_reg.rd && data_reg == mem[$past(addr_reg[6:0])])
        else $error("read trigger did not load and clear");
    a_wr_needs_write_enable_gate: assert property (@(posedge CLK_I) disable iff (any_rst)
        $rose(wr_busy) |-> $past(unlocked) && ctrl_reg.write_enable_gate)
        else $error("write began without enable or unlock");
    a_wr_no_abort: assert property (@(posedge CLK_I) disable iff (any_rst)
        (ctrl_reg.wr && !wr_finish) |=> ctrl_reg.wr)
        else $error("write trigger cleared early");
    a_err_on_abort: assert property (@(posedge CLK_I)
        (abort_rst && !por && wr_busy) |=> ctrl_reg.wr_err)
        else $error("aborted write left no error");
    a_abort_clears: assert property (@(posedge CLK_I)
        any_rst |=> data_reg == 8'h00 && addr_reg == 8'h00)
        else $error("registers not cleared by reset");
    a_done_sets: assert property (@(posedge CLK_I) disable iff (RESET_I || por)
        wr_finish |=> done_flag_reg ##1 NVM_IRQ_O == done_ie_reg)
        else $error("done flag or interrupt missed");
    a_done_sticky: assert property (@(posedge CLK_I) disable iff (RESET_I || por)
        (done_flag_reg && !sw_clr_done) |=> done_flag_reg)
        else $error("done flag cleared by hardware");
    a_unlock_zero: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (!AVS_WAITREQUEST_O && $past(hit_unl)) |-> AVS_READDATA_O == 32'h0000_0000)
        else $error("unlock register read nonzero");
    a_write_enable_gate_gate: assert property (@(posedge CLK_I) disable iff (any_rst)
        (set_wr && !write_enable_gate_now) |=> !wr_busy)
        else $error("write started with enable clear");
    a_unlock_needed: assert property (@(posedge CLK_I) disable iff (any_rst)
        (set_wr && !unlocked) |=> !wr_busy)
        else $error("write started without unlock");
    a_addr_low_bits: assert property (@(posedge CLK_I) disable iff (any_rst)
        start_wr |=> wr_addr_reg == $past(addr_reg[6:0]))
        else $error("write address not taken from low bits");
    a_write_lands: assert property (@(posedge CLK_I) disable iff (any_rst)
        wr_finish |=> mem[$past(wr_addr_reg)] == $past(wr_data_reg))
        else $error("finished write did not reach the array");
    a_wr_clears_done: assert property (@(posedge CLK_I) disable iff (any_rst)
        wr_finish |=> !ctrl_reg.wr)
        else $error("write trigger not cleared at finish");
    a_err_por_clear: assert property (@(posedge CLK_I)
        por |=> !ctrl_reg.wr_err)
        else $error("power-on reset left error flag set");
    a_no_err_asleep: assert property (@(posedge CLK_I)
        (wdt_rst && asleep && !RESET_I && !por && !w_ctrl) |=> $stable(ctrl_reg.wr_err))
        else $error("watchdog in sleep changed error flag");
    a_done_clear: assert property (@(posedge CLK_I) disable iff (RESET_I || por)
        (sw_clr_done && !wr_finish) |=> !done_flag_reg)
        else $error("software clear of done flag lost");

    //------------------------------------------------------------
    // bus and interrupt checks
    //------------------------------------------------------------
    a_irq_follows: assert property (@(posedge CLK_I) disable iff (RESET_I || por)
        (done_flag_reg && done_ie_reg) |=> NVM_IRQ_O)
        else $error("memory interrupt missing");
    a_irq_quiet: assert property (@(posedge CLK_I) disable iff (RESET_I || por)
        !done_ie_reg |=> !NVM_IRQ_O)
        else $error("memory interrupt while disabled");
    a_status_sticky: assert property (@(posedge CLK_I) disable iff (RESET_I || por)
        (irq_status_reg[0] && !icl[0]) |=> irq_status_reg[0])
        else $error("event status bit lost");
    a_bus_answer: assert property (@(posedge CLK_I) disable iff (RESET_I)
        ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O && !ack_reg) |=> !AVS_WAITREQUEST_O)
        else $error("bus request not answered");
    a_bus_one_wait: assert property (@(posedge CLK_I) disable iff (RESET_I)
        !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
        else $error("answer held longer than one cycle");
    a_rd_byte_only: assert property (@(posedge CLK_I) disable iff (RESET_I)
        !AVS_WAITREQUEST_O |-> AVS_READDATA_O[31:8] == 24'h00_0000)
        else $error("read data upper bytes not zero");
    a_unmapped_resp: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (!AVS_WAITREQUEST_O && !$past(mapped)) |-> AVS_RESPONSE_O == 2'b11)
        else $error("unmapped access not flagged");
    c_read: cover property (@(posedge CLK_I) set_rd);
    c_write_done: cover property (@(posedge CLK_I) wr_finish);
    c_write_abort: cover property (@(posedge CLK_I) abort_rst && wr_busy);
    c_irq: cover property (@(posedge CLK_I) NVM_IRQ_O);
    c_sleep_write: cover property (@(posedge CLK_I) wr_finish && asleep);

endmodule
`default_nettype wire

// file: bench/nvac_nvm_model.sv
`default_nettype none
// ----------------------------------------
// byte array behind the access control
// ----------------------------------------
module nvac_nvm_model;
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem_reg [128];
    // only seven address bits select a byte
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        mem_reg[a[6:0]] = d;
    endtask
    function automatic logic [7:0] get(input logic [7:0] a);
        return mem_reg[a[6:0]];
    endfunction
endmodule
`default_nettype wire

// file: bench/tb.sv
`include "nvac_cfg.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WCYC = 8;
    localparam logic [7:0] RF = `NVAC_IDX_FLAGS;
    localparam logic [7:0] RE = `NVAC_IDX_ENABLES;
    localparam logic [7:0] RD = `NVAC_IDX_DATA;
    localparam logic [7:0] RA = `NVAC_IDX_ADDR;
    localparam logic [7:0] RC = `NVAC_IDX_CTRL;
    localparam logic [7:0] RK = `NVAC_IDX_UNLOCK;
    logic clk = 0, rst = 1, por = 1, wdr = 0, slp = 0, rd = 0, wr = 0;
    logic [9:0] adr = '0;
    logic [31:0] wd = '0;
    logic [3:0] be = 4'h1;
    logic [9:0] exp_q[$];
    logic [9:0] e;
    logic [7:0] a, d;
    logic [7:0] rst_idx [4] = '{RF, RE, RD, RA};
    wire logic [31:0] rdat;
    wire logic [1:0] resp;
    wire logic wq, nirq, eirq;
    int n_errors = 0, samples_checked = 0, cyc = 0;
    always #2.5 clk = ~clk;
    nvac_nvm_model nvac_nvm_model_inst();
    nvac_top #(.WRITE_CYCLES(WCYC)) nvac_top_inst(.CLK_I(clk), .RESET_I(rst),
        .POWER_ON_RESET_I(por), .WATCHDOG_RESET_I(wdr), .SLEEP_I(slp),
        .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
        .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wq),
        .AVS_RESPONSE_O(resp), .NVM_IRQ_O(nirq), .EVENT_IRQ_O(eirq));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic print_verdict();
        if (exp_q.size() != 0) n_errors++;
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
        samples_checked++;
        if (got !== ex) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] v,
                       input logic [9:0] ex);
        int n;
        n = 0;
        if (!w) exp_q.push_back(ex);
        @(posedge clk);
        adr <= {idx, 2'b00};
        wd <= {24'h0, v};
        rd <= !w;
        wr <= w;
        do begin
            @(posedge clk);
            n++;
        end while (wq !== 1'b0 && n < 200);
        if (wq !== 1'b0) n_errors++;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wrr(input logic [7:0] idx, input logic [7:0] v);
        bus(1'b1, idx, v, 10'h000);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] ex);
        bus(1'b0, idx, 8'h00, {2'b00, ex});
    endtask
    task automatic start_write(input logic [7:0] aa, input logic [7:0] dd);
        wrr(RA, aa);
        wrr(RD, dd);
        wrr(RC, 8'h04);
        wrr(RK, `NVAC_KEY1);
        wrr(RK, `NVAC_KEY2);
        wrr(RC, 8'h06);
    endtask
    // ----------------------------------------
    // watcher of read answers and timeout
    // ----------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            n_errors++;
            print_verdict();
        end
        if (rd && wq === 1'b0) begin
            e = exp_q.pop_front();
            cmp("readdata", {24'h0, e[7:0]}, rdat);
            cmp("response", {30'h0, e[9:8]}, {30'h0, resp});
        end
    end
    initial begin
        d = 8'($urandom(53));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
        repeat (4) @(posedge clk);
        foreach (rst_idx[i]) rdc(rst_idx[i], 8'h00);
        rdc(RC, 8'h00);
        $display("done reset values");
        wrr(RC, 8'hF0);
        rdc(RC, 8'h00);
        rdc(RK, 8'h00);
        wrr(RD, 8'h3C);
        be <= 4'h0;
        wrr(RD, 8'hC3);
        be <= 4'h1;
        rdc(RD, 8'h3C);
        bus(1'b0, 8'h50, 8'h00, 10'h300);
        wrr(RK, `NVAC_KEY1);
        wrr(RK, `NVAC_KEY2);
        wrr(RC, 8'h02);
        rdc(RC, 8'h00);
        wrr(RC, 8'h04);
        wrr(RC, 8'h06);
        rdc(RC, 8'h04);
        repeat (WCYC + 4) @(posedge clk);
        rdc(RF, 8'h00);
        $display("done refusals");
        for (int k = 0; k < 2; k++) begin
            a = 8'($urandom) | 8'h80;
            d = 8'($urandom);
            slp <= k[0];
            wrr(RE, k[0] ? 8'h80 : 8'h00);
            start_write(a, d);
            nvac_nvm_model_inst.put(a, d);
            wrr(RC, 8'h04);
            rdc(RC, 8'h06);
            repeat (WCYC + 4) @(posedge clk);
            rdc(RC, 8'h04);
            rdc(RF, 8'h80);
            cmp("nvm_irq", {31'h0, k[0]}, {31'h0, nirq});
            wrr(RF, 8'h00);
            repeat (2) @(posedge clk);
            cmp("nvm_irq", 32'h0, {31'h0, nirq});
            slp <= 1'b0;
            wrr(RD, ~d);
            wrr(RA, a & 8'h7F);
            wrr(RC, 8'h05);
            rdc(RC, 8'h04);
            rdc(RD, nvac_nvm_model_inst.get(a));
            $display("done write %0d", k);
        end
        rdc(`NVAC_IDX_IRQ_STATUS, 8'h05);
        wrr(`NVAC_IDX_IRQ_ENABLE, 8'h05);
        repeat (2) @(posedge clk);
        cmp("event_irq", 32'h1, {31'h0, eirq});
        wrr(`NVAC_IDX_IRQ_ENABLE, 8'h00);
        repeat (2) @(posedge clk);
        cmp("event_irq", 32'h0, {31'h0, eirq});
        wrr(`NVAC_IDX_IRQ_ENABLE, 8'h05);
        wrr(`NVAC_IDX_IRQ_CLEAR, 8'h05);
        repeat (2) @(posedge clk);
        cmp("event_irq", 32'h0, {31'h0, eirq});
        rdc(`NVAC_IDX_IRQ_STATUS, 8'h00);
        $display("done events");
        for (int j = 0; j < 2; j++) begin
            start_write(8'($urandom), 8'($urandom));
            repeat (2) @(posedge clk);
            rst <= (j == 0);
            wdr <= (j == 1);
            repeat (4) @(posedge clk);
            rst <= 1'b0;
            wdr <= 1'b0;
            repeat (6) @(posedge clk);
            rdc(RC, 8'h08);
            rdc(RD, 8'h00);
            rdc(RA, 8'h00);
            if (j == 0) begin
                wrr(RC, 8'h00);
            end else begin
                rdc(`NVAC_IDX_IRQ_STATUS, 8'h02);
                por <= 1'b1;
                repeat (4) @(posedge clk);
                por <= 1'b0;
                repeat (6) @(posedge clk);
            end
            rdc(RC, 8'h00);
            $display("done abort %0d", j);
        end
        slp <= 1'b1;
        start_write(8'h11, 8'h22);
        repeat (2) @(posedge clk);
        wdr <= 1'b1;
        repeat (4) @(posedge clk);
        wdr <= 1'b0;
        repeat (WCYC + 4) @(posedge clk);
        slp <= 1'b0;
        rdc(RC, 8'h04);
        rdc(RA, 8'h11);
        rdc(RF, 8'h80);
        $display("done sleep watchdog");
        repeat (4) @(posedge clk);
        print_verdict();
    end
endmodule
`default_nettype wire
